/* logic/sccg_top.sv */
/*
  System clock select, divide and gate block: Wishbone classic slave,
  oscillator tick sampling, AHB source mux with crystal fallback, AHB and
  APB dividers, module gates, crystal presence and failure flags.
  Assumes oscillator pins are asynchronous and slower than clk_i / 2;
  sleep_i, dslp_wake_i and fast_xtal_power_on_i come from clk_i logic.
*/
// Functional notes
// - Low PLL input: 0 slow crystal, 1 slow RC.
// - High PLL input: 0 fast RC, 1 fast crystal.
// - Fast crystal failure raises CPU interrupt when enabled.
// - Slow crystal failure raises CPU interrupt when enabled.
// - Enabled slow crystal failure during sleep also requests wake-up.
// - RTC clock: 0 slow crystal, 1 slow RC.
// - Fast presence updates only while fast crystal is powered.
// - Slow presence is read-only, resets to one.
// - Fast failure flag sets on presence fall, write one clears.
// - Slow failure flag sets on presence fall, write one clears.
// - AHB source codes 0..4, others reserved, reset fast RC.
// - AHB clock is source divided by field plus one.
// - APB clock is AHB clock divided by field plus one, field reset one (ratio two).
// - AHB module gates, one bit per module, reset 0xff.
// - APB module gates, one bit per module, reset all ones.
// - Fast RC replaces a stopped fast crystal, crystal back on recovery.
// - Slow RC replaces a stopped slow crystal, crystal back on recovery.
// - Presence detection runs on slow RC ticks.
// - Deep sleep wake restores clock settings, source back to fast RC.
`timescale 1ns/100ps
`default_nettype none
`include "sccg_params.svh"
module sccg_top
  import sccg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        fast_rc_osc_i,
  input  wire logic        fast_xtal_osc_i,
  input  wire logic        high_pll_i,
  input  wire logic        slow_xtal_i,
  input  wire logic        slow_rc_i,
  input  wire logic        low_pll_i,
  input  wire logic        fast_xtal_power_on_i,
  input  wire logic        sleep_i,
  input  wire logic        dslp_wake_i,
  output logic             ahb_tick_o,
  output logic             apb_tick_o,
  output logic      [8:0]  ahb_gate_tick_o,
  output logic      [31:0] apb_gate_tick_o,
  output logic             rtc_tick_o,
  output logic      [2:0]  ahb_src_o,
  output logic             low_pll_src_o,
  output logic             high_pll_src_o,
  output logic             rtc_clk_src_o,
  output logic             irq_o,
  output logic             wakeup_o
);
  // ---------------------------------------------------------------
  // Oscillator sampling and edge ticks
  // ---------------------------------------------------------------
  logic [`SCCG_N_OSC-1:0] osc_raw;
  logic [`SCCG_N_OSC-1:0] meta_ff;
  logic [`SCCG_N_OSC-1:0] sync_ff;
  logic [`SCCG_N_OSC-1:0] last_ff;
  logic [`SCCG_N_OSC-1:0] tick;

  assign osc_raw = {low_pll_i, slow_rc_i, slow_xtal_i,
                    high_pll_i, fast_xtal_osc_i, fast_rc_osc_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else begin
      meta_ff <= osc_raw;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SCCG_N_OSC; gi++) begin : g_tick
      assign tick[gi] = sync_ff[gi] && !last_ff[gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [5:0]  ctrl_ff;
  sccg_src_t   src_ff;
  sccg_div_t   divh_ff;
  sccg_div_t   divp_ff;
  logic [8:0]  hgate_ff;
  sccg_word_t  pgate_ff;
  logic        fflag_ff;
  logic        sflag_ff;
  logic        ack_ff;
  logic        wr;
  logic        cfg_rst;
  sccg_word_t  wdat;

  // Byte-lane merge of a write
  function automatic sccg_word_t wmerge(input sccg_word_t old_v,
                                        input sccg_word_t new_v,
                                        input logic [3:0] be);
    sccg_word_t r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  assign wr      = cyc_i && stb_i && we_i && ack_ff;
  assign cfg_rst = rst_i || dslp_wake_i;

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      ctrl_ff <= `SCCG_RST_CTRL;
    end else if (wr && hit(adr_i, `SCCG_OFS_CTRL)) begin
      ctrl_ff <= 6'(wmerge(32'(ctrl_ff), dat_i, sel_i));
    end
  end

  assign wdat = wmerge(32'(src_ff), dat_i, sel_i);

  // Reserved source codes are ignored
  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      src_ff <= `SCCG_RST_SRC;
    end else if (wr && hit(adr_i, `SCCG_OFS_SRC) && wdat[2:0] <= `SCCG_SRC_LPLL) begin
      src_ff <= wdat[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      divh_ff  <= `SCCG_RST_DIVH;
      divp_ff  <= `SCCG_RST_DIVP;
      hgate_ff <= `SCCG_RST_HGATE;
      pgate_ff <= `SCCG_RST_PGATE;
    end else if (wr) begin
      if (hit(adr_i, `SCCG_OFS_DIVH)) begin
        divh_ff <= 8'(wmerge(32'(divh_ff), dat_i, sel_i));
      end
      if (hit(adr_i, `SCCG_OFS_DIVP)) begin
        divp_ff <= 8'(wmerge(32'(divp_ff), dat_i, sel_i));
      end
      if (hit(adr_i, `SCCG_OFS_HGATE)) begin
        hgate_ff <= 9'(wmerge(32'(hgate_ff), dat_i, sel_i));
      end
      if (hit(adr_i, `SCCG_OFS_PGATE)) begin
        pgate_ff <= wmerge(pgate_ff, dat_i, sel_i);
      end
    end
  end

  // ---------------------------------------------------------------
  // Crystal presence and failure flags
  // ---------------------------------------------------------------
  logic fast_pres;
  logic slow_pres;
  logic fast_pres_ff;
  logic slow_pres_ff;
  logic clr_f;
  logic clr_s;

  sccg_xtal_mon #(.WIN(`SCCG_MON_WIN), .RST_VAL(1'b0)) u_fast_mon (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .en_i        (fast_xtal_power_on_i),
    .ref_tick_i  (tick[`SCCG_I_SRC]),
    .xtal_tick_i (tick[`SCCG_I_FXO]),
    .present_o   (fast_pres)
  );

  sccg_xtal_mon #(.WIN(`SCCG_MON_WIN), .RST_VAL(1'b1)) u_slow_mon (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .en_i        (1'b1),
    .ref_tick_i  (tick[`SCCG_I_SRC]),
    .xtal_tick_i (tick[`SCCG_I_SXO]),
    .present_o   (slow_pres)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_pres_ff <= 1'b0;
      slow_pres_ff <= 1'b1;
    end else begin
      fast_pres_ff <= fast_pres;
      slow_pres_ff <= slow_pres;
    end
  end

  assign clr_f = wr && hit(adr_i, `SCCG_OFS_STS) && sel_i[0] && dat_i[`SCCG_B_FFLAG];
  assign clr_s = wr && hit(adr_i, `SCCG_OFS_STS) && sel_i[0] && dat_i[`SCCG_B_SFLAG];

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fflag_ff <= 1'b0;
      sflag_ff <= 1'b0;
    end else begin
      fflag_ff <= (fast_pres_ff && !fast_pres) || (fflag_ff && !clr_f);
      sflag_ff <= (slow_pres_ff && !slow_pres) || (sflag_ff && !clr_s);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o    <= 1'b0;
      wakeup_o <= 1'b0;
    end else begin
      irq_o    <= (fflag_ff && ctrl_ff[`SCCG_B_FIE]) ||
                  (sflag_ff && ctrl_ff[`SCCG_B_SIE]);
      wakeup_o <= sleep_i && sflag_ff && ctrl_ff[`SCCG_B_SIE];
    end
  end

  // ---------------------------------------------------------------
  // Source selection with crystal fallback
  // ---------------------------------------------------------------
  logic      rtc_rc;
  logic      rtc_tick;
  logic      cur_tick;
  sccg_src_t act_src_ff;

  assign rtc_rc   = ctrl_ff[`SCCG_B_RTC] || !slow_pres;
  assign rtc_tick = rtc_rc ? tick[`SCCG_I_SRC] : tick[`SCCG_I_SXO];

  always_comb begin
    case (act_src_ff)
      `SCCG_SRC_FRC:  cur_tick = tick[`SCCG_I_FRC];
      `SCCG_SRC_FXO:  cur_tick = fast_pres ? tick[`SCCG_I_FXO] : tick[`SCCG_I_FRC];
      `SCCG_SRC_HPLL: cur_tick = tick[`SCCG_I_HPLL];
      `SCCG_SRC_RTC:  cur_tick = rtc_tick;
      `SCCG_SRC_LPLL: cur_tick = tick[`SCCG_I_LPLL];
      default:        cur_tick = tick[`SCCG_I_FRC];
    endcase
  end

  // Move to a new source only right after the old one ticked
  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      act_src_ff <= `SCCG_RST_SRC;
    end else if (cur_tick) begin
      act_src_ff <= src_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_pll_src_o  <= 1'b0;
      high_pll_src_o <= 1'b0;
      rtc_clk_src_o  <= 1'b0;
      rtc_tick_o     <= 1'b0;
      ahb_src_o      <= `SCCG_RST_SRC;
    end else begin
      low_pll_src_o  <= ctrl_ff[`SCCG_B_LPLL] || !slow_pres;
      high_pll_src_o <= ctrl_ff[`SCCG_B_HPLL] && fast_pres;
      rtc_clk_src_o  <= rtc_rc;
      rtc_tick_o     <= rtc_tick;
      ahb_src_o      <= act_src_ff;
    end
  end

  // ---------------------------------------------------------------
  // Dividers and gates
  // ---------------------------------------------------------------
  logic ahb_pulse;
  logic apb_pulse;

  sccg_clk_div #(.W(8)) u_ahb_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (cur_tick),
    .div_i   (divh_ff),
    .pulse_o (ahb_pulse)
  );

  sccg_clk_div #(.W(8)) u_apb_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (ahb_pulse),
    .div_i   (divp_ff),
    .pulse_o (apb_pulse)
  );

  // Gating a whole pulse keeps every gated clock free of runts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ahb_tick_o      <= 1'b0;
      apb_tick_o      <= 1'b0;
      ahb_gate_tick_o <= '0;
      apb_gate_tick_o <= '0;
    end else begin
      ahb_tick_o      <= ahb_pulse;
      apb_tick_o      <= apb_pulse;
      ahb_gate_tick_o <= {9{ahb_pulse}} & hgate_ff;
      apb_gate_tick_o <= {32{apb_pulse}} & pgate_ff;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone classic slave
  // ---------------------------------------------------------------
  sccg_word_t rdat;

  always_comb begin
    rdat = '0;
    case ({adr_i[7:2], 2'b00})
      `SCCG_OFS_CTRL:  rdat = 32'(ctrl_ff);
      `SCCG_OFS_STS:   rdat = 32'({fast_pres, slow_pres, fflag_ff, sflag_ff});
      `SCCG_OFS_SRC:   rdat = 32'(src_ff);
      `SCCG_OFS_DIVH:  rdat = 32'(divh_ff);
      `SCCG_OFS_DIVP:  rdat = 32'(divp_ff);
      `SCCG_OFS_HGATE: rdat = 32'(hgate_ff);
      `SCCG_OFS_PGATE: rdat = pgate_ff;
      default:         rdat = '0;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_o  <= '0;
    end else begin
      ack_ff <= cyc_i && stb_i && !ack_ff;
      dat_o  <= (cyc_i && stb_i && !we_i && !ack_ff) ? rdat : '0;
    end
  end

  assign ack_o = ack_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_lpll_route: assert property (1 |=> low_pll_src_o == $past(ctrl_ff[`SCCG_B_LPLL] || !slow_pres))
    else $error("low PLL input route wrong");
  chk_hpll_route: assert property (1 |=> high_pll_src_o == $past(ctrl_ff[`SCCG_B_HPLL] && fast_pres))
    else $error("high PLL input route wrong");
  chk_fast_irq: assert property (fflag_ff && ctrl_ff[`SCCG_B_FIE] |=> irq_o)
    else $error("fast crystal failure interrupt missing");
  chk_irq_cause: assert property (irq_o |-> $past(fflag_ff || sflag_ff))
    else $error("interrupt without a failure flag");
  chk_sleep_wake: assert property (sleep_i && sflag_ff && ctrl_ff[`SCCG_B_SIE] |=> wakeup_o)
    else $error("wake-up request missing");
  chk_fast_flag: assert property ($fell(fast_pres) |=> fflag_ff)
    else $error("fast failure flag not set on loss");
  chk_slow_hold: assert property (sflag_ff && !clr_s |=> sflag_ff)
    else $error("slow failure flag dropped without clear");
  chk_src_switch: assert property ($changed(act_src_ff) && !$past(cfg_rst) |-> $past(cur_tick))
    else $error("source switched between ticks");
  chk_pgate_mask: assert property ((apb_gate_tick_o & ~$past(pgate_ff)) == '0)
    else $error("gated APB module got a tick");
  chk_wake_reset: assert property (dslp_wake_i |=> src_ff == `SCCG_RST_SRC && divp_ff == `SCCG_RST_DIVP)
    else $error("deep sleep wake did not restore settings");

  cov_fast_loss:  cover property ($rose(fflag_ff));
  cov_src_change: cover property ($changed(act_src_ff));
  cov_apb_tick:   cover property (apb_tick_o);
endmodule // sccg_top
`default_nettype wire

/* logic/sccg_params.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  system clock select, divide and gate block.
  Assumes inclusion by bare name from every file of the block.
*/
`ifndef SCCG_PARAMS_SVH
`define SCCG_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SCCG_OFS_CTRL   8'h00
`define SCCG_OFS_STS    8'h04
`define SCCG_OFS_SRC    8'h08
`define SCCG_OFS_DIVH   8'h0c
`define SCCG_OFS_DIVP   8'h10
`define SCCG_OFS_HGATE  8'h14
`define SCCG_OFS_PGATE  8'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SCCG_B_LPLL     5
`define SCCG_B_HPLL     4
`define SCCG_B_FIE      3
`define SCCG_B_SIE      2
`define SCCG_B_RTC      1
`define SCCG_B_FPRES    3
`define SCCG_B_SPRES    2
`define SCCG_B_FFLAG    1
`define SCCG_B_SFLAG    0

// ---------------------------------------------------------------
// Reset values and source codes
// ---------------------------------------------------------------
`define SCCG_RST_CTRL   6'h00
`define SCCG_RST_SRC    3'h0
`define SCCG_RST_DIVH   8'h00
`define SCCG_RST_DIVP   8'h01
`define SCCG_RST_HGATE  9'h0ff
`define SCCG_RST_PGATE  32'hffffffff
`define SCCG_SRC_FRC    3'h0
`define SCCG_SRC_FXO    3'h1
`define SCCG_SRC_HPLL   3'h2
`define SCCG_SRC_RTC    3'h3
`define SCCG_SRC_LPLL   3'h4

// ---------------------------------------------------------------
// Oscillator input indices and monitor window (slow RC ticks)
// ---------------------------------------------------------------
`define SCCG_I_FRC      0
`define SCCG_I_FXO      1
`define SCCG_I_HPLL     2
`define SCCG_I_SXO      3
`define SCCG_I_SRC      4
`define SCCG_I_LPLL     5
`define SCCG_N_OSC      6
`define SCCG_MON_WIN    4

`endif

/* logic/sccg_pkg.sv */
/*
  Types of the system clock select, divide and gate block.
  Assumes sccg_params.svh is on the include path.
*/
`default_nettype none
package sccg_pkg;
  typedef logic [2:0]  sccg_src_t;
  typedef logic [7:0]  sccg_div_t;
  typedef logic [31:0] sccg_word_t;
endpackage
`default_nettype wire

/* logic/sccg_clk_div.sv */
/*
  Divider of a tick stream by N+1, N loaded only at the wrap point.
  Assumes tick_i is a one-cycle pulse on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sccg_params.svh"
module sccg_clk_div
  import sccg_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] div_i,
  output logic              pulse_o
);
  logic [W-1:0] cnt_ff;

  // New ratio taken only at the wrap, so no runt period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (tick_i) begin
      cnt_ff <= (cnt_ff == '0) ? div_i : cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= tick_i && (cnt_ff == '0);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_div_wrap: assert property (tick_i && cnt_ff == '0 |=> pulse_o)
    else $error("divider missed its wrap pulse");
  chk_div_quiet: assert property (!(tick_i && cnt_ff == '0) |=> !pulse_o)
    else $error("divider pulsed off its wrap");
endmodule // sccg_clk_div
`default_nettype wire

/* logic/sccg_xtal_mon.sv */
/*
  Crystal presence monitor: counts slow RC ticks and looks for crystal
  edges within each window. Assumes both ticks are one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sccg_params.svh"
module sccg_xtal_mon
  import sccg_pkg::*;
#(
  parameter int   WIN     = `SCCG_MON_WIN,
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  input  wire logic ref_tick_i,
  input  wire logic xtal_tick_i,
  output logic      present_o
);
  logic [7:0] win_ff;
  logic       seen_ff;
  logic       win_end;

  assign win_end = ref_tick_i && (win_ff == 8'(WIN - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_ff <= '0;
    end else if (ref_tick_i) begin
      win_ff <= win_end ? '0 : win_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || win_end) begin
      seen_ff <= 1'b0;
    end else if (xtal_tick_i) begin
      seen_ff <= 1'b1;
    end
  end

  // Disabled monitor keeps its last verdict
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      present_o <= RST_VAL;
    end else if (en_i && win_end) begin
      present_o <= seen_ff || xtal_tick_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_mon_hold: assert property (!en_i |=> $stable(present_o))
    else $error("presence changed while monitor disabled");
endmodule // sccg_xtal_mon
`default_nettype wire

/* verification/sccg_osc_model.sv */
/*
  Oscillator model for the far side of the clock block: a square wave
  of HALF clk_i cycles per level, stopped and held low while run_i is low.
  Assumes run_i comes from the bench and is low until reset is over.
*/
`timescale 1ns/100ps
`default_nettype none
module sccg_osc_model #(
  parameter int HALF = 4
) (
  input  wire logic clk_i,
  input  wire logic run_i,
  output logic      osc_o
);
  int cnt_ff;

  // ---------------------------------------------------------------
  // Toggle every HALF cycles while running
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      cnt_ff <= 0;
      osc_o  <= 1'b0;
    end else if (cnt_ff == HALF - 1) begin
      cnt_ff <= 0;
      osc_o  <= ~osc_o;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule // sccg_osc_model
`default_nettype wire

/* verification/tb_top.sv */
/*
  Self-checking bench of the clock select, divide and gate block.
  Assumes the design files and sccg_params.svh are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sccg_params.svh"
module tb_top
  import sccg_pkg::*;
;
  localparam int HALFS[6] = '{3, 4, 5, 7, 5, 6};
  localparam logic [7:0] RA[8] = '{`SCCG_OFS_CTRL, `SCCG_OFS_STS, `SCCG_OFS_SRC, `SCCG_OFS_DIVH,
                                   `SCCG_OFS_DIVP, `SCCG_OFS_HGATE, `SCCG_OFS_PGATE, 8'h1c};
  localparam sccg_word_t RV[8] = '{32'h0, 32'h4, 32'h0, 32'h0, 32'h1, 32'h0ff, 32'hffffffff, 32'h0};

  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       cyc_i = 1'b0;
  logic       stb_i = 1'b0;
  logic       we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  sccg_word_t dat_i = 32'h0;
  logic       fast_xtal_power_on_i = 1'b0;
  logic       sleep_i = 1'b0;
  logic       dslp_wake_i = 1'b0;
  logic [5:0] osc_run = 6'h00;
  wire  [5:0] osc;
  sccg_word_t dat_o;
  sccg_word_t apb_gate_tick_o;
  logic [8:0] ahb_gate_tick_o;
  logic [2:0] ahb_src_o;
  logic       ack_o, ahb_tick_o, apb_tick_o, rtc_tick_o, low_pll_src_o;
  logic       high_pll_src_o, rtc_clk_src_o, irq_o, wakeup_o;
  int         failures = 0;
  int         tests_run = 0;

  always #5 clk_i = ~clk_i;

  for (genvar gi = 0; gi < 6; gi++) begin : g_osc
    sccg_osc_model #(.HALF(HALFS[gi])) u_osc (.clk_i(clk_i), .run_i(osc_run[gi]), .osc_o(osc[gi]));
  end

  sccg_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .fast_rc_osc_i(osc[0]), .fast_xtal_osc_i(osc[1]), .high_pll_i(osc[2]), .slow_xtal_i(osc[3]),
    .slow_rc_i(osc[4]), .low_pll_i(osc[5]), .fast_xtal_power_on_i, .sleep_i, .dslp_wake_i,
    .ahb_tick_o, .apb_tick_o, .ahb_gate_tick_o, .apb_gate_tick_o, .rtc_tick_o, .ahb_src_o,
    .low_pll_src_o, .high_pll_src_o, .rtc_clk_src_o, .irq_o, .wakeup_o);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Waits for ack as long as it takes; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input sccg_word_t d, output sccg_word_t q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    chk("ack", 32'h1, {31'h0, ack_o});
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input sccg_word_t d);
    sccg_word_t q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input sccg_word_t exp);
    sccg_word_t q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, exp, q);
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return ahb_tick_o;
      1: return apb_tick_o;
      2: return rtc_tick_o;
      default: return irq_o;
    endcase
  endfunction

  task automatic wait_on(input int k, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pick(k) !== 1'b1 && n < lim);
  endtask

  // Second tick onward, so a stale divider count is skipped
  task automatic gap_chk(input string nm, input int k, input int exp);
    int n;
    wait_on(k, 5000);
    wait_on(k, 5000);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pick(k) !== 1'b1 && n < 5000);
    chk(nm, 32'(exp), 32'(n));
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd_chk("reset value", RA[i], RV[i]);
    wr(8'h1c, 32'hffffffff);
    rd_chk("unmapped", 8'h1c, 32'h0);
    wr(`SCCG_OFS_STS, 32'hfffffff0);
    rd_chk("status", `SCCG_OFS_STS, 32'h4);
    chk("rtc src", 32'h0, {31'h0, rtc_clk_src_o});
    chk("low pll src", 32'h0, {31'h0, low_pll_src_o});
  endtask

  task automatic t_divide();
    gap_chk("ahb gap", 0, 6);
    gap_chk("apb gap", 1, 12);
    wr(`SCCG_OFS_DIVH, 32'hff);
    gap_chk("ahb gap", 0, 1536);
    wr(`SCCG_OFS_DIVH, 32'h1);
    wr(`SCCG_OFS_DIVP, 32'h2);
    gap_chk("ahb gap", 0, 12);
    gap_chk("apb gap", 1, 36);
    wr(`SCCG_OFS_HGATE, 32'h150);
    repeat (2) wait_on(0, 5000);
    chk("ahb gates", 32'h150, {23'h0, ahb_gate_tick_o});
    wr(`SCCG_OFS_PGATE, 32'h00600006);
    repeat (2) wait_on(1, 5000);
    chk("apb gates", 32'h00600006, apb_gate_tick_o);
  endtask

  task automatic t_fast();
    wr(`SCCG_OFS_CTRL, 32'h18);
    fast_xtal_power_on_i <= 1'b1;
    osc_run[1] <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("high pll src", 32'h1, {31'h0, high_pll_src_o});
    wr(`SCCG_OFS_SRC, 32'h1);
    repeat (200) @(posedge clk_i);
    chk("ahb src", 32'h1, {29'h0, ahb_src_o});
    gap_chk("ahb gap", 0, 16);
    fast_xtal_power_on_i <= 1'b0;
    osc_run[1] <= 1'b0;
    repeat (200) @(posedge clk_i);
    rd_chk("status", `SCCG_OFS_STS, 32'hc);
    fast_xtal_power_on_i <= 1'b1;
    wait_on(3, 400);
    chk("irq", 32'h1, {31'h0, irq_o});
    chk("high pll src", 32'h0, {31'h0, high_pll_src_o});
    gap_chk("ahb gap", 0, 12);
    rd_chk("status", `SCCG_OFS_STS, 32'h6);
    wr(`SCCG_OFS_STS, 32'h2);
    rd_chk("status", `SCCG_OFS_STS, 32'h4);
    chk("irq", 32'h0, {31'h0, irq_o});
    osc_run[1] <= 1'b1;
    repeat (200) @(posedge clk_i);
    gap_chk("ahb gap", 0, 16);
  endtask

  task automatic t_src();
    for (int s = 0; s < 5; s++) begin
      wr(`SCCG_OFS_SRC, 32'(s));
      repeat (300) @(posedge clk_i);
      chk("ahb src", 32'(s), {29'h0, ahb_src_o});
    end
    wr(`SCCG_OFS_SRC, 32'h5);
    repeat (50) @(posedge clk_i);
    chk("ahb src", 32'h4, {29'h0, ahb_src_o});
    rd_chk("src reg", `SCCG_OFS_SRC, 32'h4);
    wr(`SCCG_OFS_SRC, 32'h0);
  endtask

  task automatic t_slow();
    wr(`SCCG_OFS_CTRL, 32'h4);
    sleep_i <= 1'b1;
    gap_chk("rtc gap", 2, 14);
    wr(`SCCG_OFS_CTRL, 32'h26);
    repeat (10) @(posedge clk_i);
    chk("rtc src", 32'h1, {31'h0, rtc_clk_src_o});
    chk("low pll src", 32'h1, {31'h0, low_pll_src_o});
    gap_chk("rtc gap", 2, 10);
    wr(`SCCG_OFS_CTRL, 32'h4);
    repeat (10) @(posedge clk_i);
    chk("low pll src", 32'h0, {31'h0, low_pll_src_o});
    osc_run[3] <= 1'b0;
    wait_on(3, 400);
    chk("irq", 32'h1, {31'h0, irq_o});
    chk("wakeup", 32'h1, {31'h0, wakeup_o});
    chk("rtc src", 32'h1, {31'h0, rtc_clk_src_o});
    gap_chk("rtc gap", 2, 10);
    rd_chk("status", `SCCG_OFS_STS, 32'h9);
    osc_run[3] <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("rtc src", 32'h0, {31'h0, rtc_clk_src_o});
    rd_chk("status", `SCCG_OFS_STS, 32'hd);
    wr(`SCCG_OFS_STS, 32'h1);
    rd_chk("status", `SCCG_OFS_STS, 32'hc);
    chk("wakeup", 32'h0, {31'h0, wakeup_o});
    sleep_i <= 1'b0;
  endtask

  task automatic t_deep();
    wr(`SCCG_OFS_DIVH, 32'h33);
    wr(`SCCG_OFS_SRC, 32'h2);
    repeat (100) @(posedge clk_i);
    dslp_wake_i <= 1'b1;
    @(posedge clk_i);
    dslp_wake_i <= 1'b0;
    for (int i = 0; i < 7; i++) if (i != 1) rd_chk("wake value", RA[i], RV[i]);
    rd_chk("status", `SCCG_OFS_STS, 32'hc);
    repeat (100) @(posedge clk_i);
    chk("ahb src", 32'h0, {29'h0, ahb_src_o});
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    osc_run <= 6'b111101;
    repeat (100) @(posedge clk_i);
    t_reset();
    t_divide();
    t_fast();
    t_src();
    t_slow();
    t_deep();
    wrap_up();
  end

  initial begin
    #400000;
    failures++;
    $display("MISMATCH watchdog expected done seen timeout");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
